// ==== common/reset_cause_pkg.sv ====
`default_nettype none
package reset_cause_pkg;
  // register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFF_CAUSE = 8'h00;
  localparam logic [7:0] OFF_EVT = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_STATE = 8'h0c;
  // reset cause register fields
  localparam int BIT_PRIO = 7;
  localparam int BIT_MISMATCH = 5;
  localparam int BIT_INSTR = 4;
  localparam int BIT_WDOG = 3;
  localparam int BIT_PWRDN = 2;
  localparam int BIT_POR = 1;
  localparam int BIT_LOWSUP = 0;
  localparam logic [7:0] CAUSE_RST = 8'h3c;
  localparam logic [7:0] CAUSE_WMASK = 8'hb3;
  // event status and mask fields
  localparam int EV_MISMATCH = 0;
  localparam int EV_INSTR = 1;
  localparam int EV_WDOG = 2;
  localparam int EV_CLRPIN = 3;
  localparam int EV_STACK = 4;
  localparam int EV_LOWSUP = 5;
  localparam int EV_WAKE = 6;
  localparam int EV_W = 7;
  localparam logic [EV_W-1:0] EVT_RST = 7'h00;
  localparam logic [EV_W-1:0] MASK_RST = 7'h00;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int RST_HOLD_NS = 50;
  localparam int RST_HOLD_CYC =
    (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CW = 8;
  localparam logic [HOLD_CW-1:0] HOLD_LAST = 8'(RST_HOLD_CYC - 1);
  // interrupt vectors loaded on wake-up
  localparam logic [15:0] VEC_HIGH = 16'h0008;
  localparam logic [15:0] VEC_LOW = 16'h0018;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    SEQ_HOLD = 3'b001,
    SEQ_RELOAD = 3'b010,
    SEQ_RUN = 3'b100
  } seq_e;
endpackage
`default_nettype wire

// ==== common/cfg_if.sv ====
`default_nettype none
interface cfg_if #(
  parameter int N_WORDS = 4,
  parameter int WORD_W = 16
);
  logic reload;
  logic [N_WORDS*WORD_W-1:0] flashWords;
  logic [N_WORDS*WORD_W-1:0] disturb;
  logic [N_WORDS*WORD_W-1:0] activeWords;
  logic mismatch;
  modport seq (output reload, output flashWords, output disturb,
    input activeWords, input mismatch);
  modport mon (input reload, input flashWords, input disturb,
    output activeWords, output mismatch);
endinterface
`default_nettype wire

// ==== hdl/config_monitor.sv ====
`default_nettype none
module config_monitor #(
  parameter int N_WORDS = 4,
  parameter int WORD_W = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic clkEn,
  cfg_if.mon port
);
  logic [WORD_W-1:0] active_ff [N_WORDS];
  logic [WORD_W-1:0] shadow_ff [N_WORDS];
  logic [N_WORDS-1:0] wordBad;
  logic mismatch_ff;

  // shadow resets to the complement of active so an idle block reads clean
  for (genvar i = 0; i < N_WORDS; i++)
  begin : g_word
    assign wordBad[i] = active_ff[i] != ~shadow_ff[i]; // RULE_01
    assign port.activeWords[i*WORD_W +: WORD_W] = active_ff[i];
    always_ff @(posedge clk)
    begin
      if (srst)
      begin
        active_ff[i] <= '0;
        shadow_ff[i] <= '1;
      end
      else if (clkEn)
      begin
        if (port.reload)
        begin
          active_ff[i] <= port.flashWords[i*WORD_W +: WORD_W];
          shadow_ff[i] <= ~port.flashWords[i*WORD_W +: WORD_W];
        end
        else
        begin
          active_ff[i] <= active_ff[i] ^ port.disturb[i*WORD_W +: WORD_W];
        end
      end
    end
  end

  // compare runs every enabled cycle; masked only while words reload
  always_ff @(posedge clk)
  begin
    if (srst)
      mismatch_ff <= 1'b0;
    else if (clkEn)
      mismatch_ff <= (|wordBad) & ~port.reload; // RULE_01
  end
  assign port.mismatch = mismatch_ff;

  cmp_flag_a: assert property (@(posedge clk) disable iff (srst) // RULE_01
    (|wordBad) && !port.reload && clkEn |=> port.mismatch)
    else $error("word mismatch not flagged");
endmodule
`default_nettype wire

// ==== hdl/reset_cause_unit.sv ====
// Overview of operation
// [RULE_01] Active config words are checked against shadows every cycle.
// [RULE_02] Any config word mismatch starts a hard reset on its own.
// [RULE_03] A mismatch clears the active-low mismatch flag, cause bit 5.
// [RULE_04] Resets other than a mismatch leave the mismatch flag as it was; a power reset (srst) loads it with 1.
// [RULE_05] A mismatch reset holds and restarts like every other hard reset.
// [RULE_06] Every hard or power reset reloads the active words from flash.
// [RULE_07] A watchdog expiry in sleep wakes the core and keeps registers.
// [RULE_08] Each reset type sets or clears its own cause flags.
// [RULE_09] Split enable 0 gives one interrupt level, 1 enables two levels.
// [RULE_10] An interrupt wake-up with a global enable set loads the vector.
// [RULE_11] Software writes a cleared cause flag back to 1 after reading it.
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`default_nettype none
module reset_cause_unit
  import reset_cause_pkg::*;
#(
  parameter int N_WORDS = 4,
  parameter int WORD_W = 16,
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic clkEn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [N_WORDS*WORD_W-1:0] flashCfg,
  input wire logic [N_WORDS*WORD_W-1:0] cfgDisturb,
  output logic [N_WORDS*WORD_W-1:0] activeCfg,
  input wire logic clrPinReq,
  input wire logic rstInstrReq,
  input wire logic wdogExpire,
  input wire logic stackFullReq,
  input wire logic stackUnderReq,
  input wire logic lowSupplyReq,
  input wire logic sleepMode,
  input wire logic irqWake,
  input wire logic irqLowLevel,
  input wire logic gieHigh,
  input wire logic gieLow,
  output logic coreRst,
  output logic wakePulse,
  output logic vecLoad,
  output logic [15:0] vecAddr,
  output logic priorityEn,
  output logic irq
);
  cfg_if #(.N_WORDS(N_WORDS), .WORD_W(WORD_W)) cfg ();

  seq_e state_ff, nxt_state;
  logic [HOLD_CW-1:0] holdCnt_ff, nxt_holdCnt;
  logic [7:0] cause_ff, nxt_cause;
  logic [EV_W-1:0] evt_ff, nxt_evt, mask_ff, evtSet, evtClr;
  logic coreRst_ff, wake_ff, vecLoad_ff, priorityEn_ff, irq_ff;
  logic [15:0] vecAddr_ff;
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;

  config_monitor #(.N_WORDS(N_WORDS), .WORD_W(WORD_W)) u_mon (
    .clk(clk),
    .srst(srst),
    .clkEn(clkEn),
    .port(cfg.mon)
  );

  // event decode
  // events only count while running; a reset in progress already restarts
  wire running = state_ff == SEQ_RUN;
  wire mmEvt = running & cfg.mismatch; // RULE_02
  wire instrEvt = running & rstInstrReq;
  wire wdogRst = running & wdogExpire & ~sleepMode;
  wire wdogWake = running & wdogExpire & sleepMode; // RULE_07
  wire pinEvt = running & clrPinReq;
  wire stackEvt = running & (stackFullReq | stackUnderReq);
  wire lowEvt = running & lowSupplyReq;
  wire irqWk = running & irqWake & sleepMode;
  wire hardReq = mmEvt | instrEvt | wdogRst | pinEvt | stackEvt |
    lowEvt; // RULE_05
  wire gieAny = gieHigh | gieLow;
  wire useLowVec = cause_ff[BIT_PRIO] & irqLowLevel; // RULE_09

  assign cfg.reload = state_ff == SEQ_RELOAD; // RULE_06
  assign cfg.flashWords = flashCfg;
  assign cfg.disturb = cfgDisturb;

  // restart sequencer
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      SEQ_HOLD: if (holdCnt_ff == HOLD_LAST) nxt_state = SEQ_RELOAD;
      SEQ_RELOAD: nxt_state = SEQ_RUN; // RULE_06
      SEQ_RUN: if (hardReq) nxt_state = SEQ_HOLD; // RULE_05
      default: nxt_state = SEQ_HOLD;
    endcase
  end
  assign nxt_holdCnt = (state_ff == SEQ_HOLD) ? holdCnt_ff + 1'b1 : '0;

  // bus write and read decode
  wire [ADDR_W-1:0] awWord = {awaddr_ff[ADDR_W-1:2], 2'b00};
  wire [ADDR_W-1:0] arWord = {araddr[ADDR_W-1:2], 2'b00};
  wire doWrite = ~awready_ff & ~wready_ff & ~bvalid_ff;
  wire lane0 = doWrite & wstrb_ff[0];
  wire wrCause = lane0 & (awWord == OFF_CAUSE);
  wire wrEvt = lane0 & (awWord == OFF_EVT);
  wire wrMask = lane0 & (awWord == OFF_MASK);
  wire wrHit = (awWord == OFF_CAUSE) || (awWord == OFF_EVT) ||
    (awWord == OFF_MASK) || (awWord == OFF_STATE);
  wire rdHit = (arWord == OFF_CAUSE) || (arWord == OFF_EVT) ||
    (arWord == OFF_MASK) || (arWord == OFF_STATE);
  wire arHs = arvalid & arready_ff;
  wire [31:0] rdMux = (arWord == OFF_CAUSE) ? {24'h00_0000, cause_ff} :
    (arWord == OFF_EVT) ? {{(32-EV_W){1'b0}}, evt_ff} :
    (arWord == OFF_MASK) ? {{(32-EV_W){1'b0}}, mask_ff} :
    (arWord == OFF_STATE) ? {27'h000_0000, state_ff, coreRst_ff,
    cfg.mismatch} : 32'h0000_0000;

  // cause flags
  // hardware updates come after the software write so the event wins
  always_comb
  begin
    nxt_cause = cause_ff;
    if (wrCause)
      nxt_cause = (cause_ff & ~CAUSE_WMASK) | (wdata_ff[7:0] & CAUSE_WMASK);
    if (lowEvt)
    begin
      nxt_cause[BIT_INSTR] = 1'b1; // RULE_08
      nxt_cause[BIT_WDOG] = 1'b1;
      nxt_cause[BIT_PWRDN] = 1'b1;
      nxt_cause[BIT_LOWSUP] = 1'b0; // RULE_04
    end
    if (pinEvt)
    begin
      nxt_cause[BIT_WDOG] = 1'b1; // RULE_08
      if (sleepMode)
        nxt_cause[BIT_PWRDN] = 1'b0;
    end
    if (wdogRst)
      nxt_cause[BIT_WDOG] = 1'b0; // RULE_08
    if (wdogWake)
    begin
      nxt_cause[BIT_WDOG] = 1'b0; // RULE_07
      nxt_cause[BIT_PWRDN] = 1'b0;
    end
    if (irqWk)
      nxt_cause[BIT_PWRDN] = 1'b0; // RULE_08
    if (instrEvt)
      nxt_cause[BIT_INSTR] = 1'b0; // RULE_08
    if (mmEvt)
      nxt_cause[BIT_MISMATCH] = 1'b0; // RULE_03
  end

  // event status and interrupt
  assign evtSet[EV_MISMATCH] = mmEvt;
  assign evtSet[EV_INSTR] = instrEvt;
  assign evtSet[EV_WDOG] = wdogRst | wdogWake;
  assign evtSet[EV_CLRPIN] = pinEvt;
  assign evtSet[EV_STACK] = stackEvt;
  assign evtSet[EV_LOWSUP] = lowEvt;
  assign evtSet[EV_WAKE] = wdogWake | irqWk;
  assign evtClr = wrEvt ? wdata_ff[EV_W-1:0] : '0;
  assign nxt_evt = (evt_ff & ~evtClr) | evtSet;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_ff <= SEQ_HOLD;
      holdCnt_ff <= '0;
      cause_ff <= CAUSE_RST;
      coreRst_ff <= 1'b1;
      evt_ff <= EVT_RST;
      mask_ff <= MASK_RST;
      irq_ff <= 1'b0;
      priorityEn_ff <= 1'b0;
    end
    else if (clkEn)
    begin
      state_ff <= nxt_state;
      holdCnt_ff <= nxt_holdCnt;
      cause_ff <= nxt_cause;
      coreRst_ff <= nxt_state != SEQ_RUN; // RULE_05
      evt_ff <= nxt_evt;
      if (wrMask)
        mask_ff <= wdata_ff[EV_W-1:0];
      irq_ff <= |(nxt_evt & (wrMask ? wdata_ff[EV_W-1:0] : mask_ff));
      priorityEn_ff <= nxt_cause[BIT_PRIO]; // RULE_09
    end
  end

  // wake-up resumes in place; vector only when a global enable is set
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wake_ff <= 1'b0;
      vecLoad_ff <= 1'b0;
      vecAddr_ff <= VEC_HIGH;
    end
    else if (clkEn)
    begin
      wake_ff <= wdogWake | irqWk; // RULE_07
      vecLoad_ff <= irqWk & gieAny; // RULE_10
      if (irqWk)
        vecAddr_ff <= useLowVec ? VEC_LOW : VEC_HIGH; // RULE_10
    end
  end

  // AXI4-Lite slave
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end
    else if (clkEn)
    begin
      if (awvalid & awready_ff)
      begin
        awready_ff <= 1'b0;
        awaddr_ff <= awaddr;
      end
      if (wvalid & wready_ff)
      begin
        wready_ff <= 1'b0;
        wdata_ff <= wdata;
        wstrb_ff <= wstrb;
      end
      if (doWrite)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_ff & bready)
      begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end
    else if (clkEn)
    begin
      if (arHs)
      begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rdata_ff <= rdMux;
        rresp_ff <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_ff & rready)
      begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign activeCfg = cfg.activeWords;
  assign coreRst = coreRst_ff;
  assign wakePulse = wake_ff;
  assign vecLoad = vecLoad_ff;
  assign vecAddr = vecAddr_ff;
  assign priorityEn = priorityEn_ff;
  assign irq = irq_ff;

  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  sequence holdSeq;
    coreRst_ff [*6] ##1 !coreRst_ff;
  endsequence

  mm_starts_a: assert property (mmEvt && clkEn |=> coreRst_ff) // RULE_02
    else $error("mismatch did not start reset");
  flag_cleared_a: assert property ( // RULE_03
    mmEvt && clkEn |=> !cause_ff[BIT_MISMATCH])
    else $error("mismatch flag not cleared");
  flag_kept_a: assert property ( // RULE_04
    clkEn && !mmEvt && !wrCause |=> $stable(cause_ff[BIT_MISMATCH]))
    else $error("mismatch flag moved without mismatch");
  hold_len_a: assert property (disable iff (srst || !clkEn) // RULE_05
    $rose(coreRst_ff) |-> holdSeq)
    else $error("hard reset hold length wrong");
  reload_seen_a: assert property ( // RULE_06
    $rose(coreRst_ff) |-> ##[1:8] cfg.reload)
    else $error("config not reloaded after reset");
  wdog_wake_a: assert property ( // RULE_07
    wdogWake && !hardReq && clkEn |=> wake_ff && !coreRst_ff &&
    !cause_ff[BIT_WDOG] && !cause_ff[BIT_PWRDN])
    else $error("watchdog wake handled as reset");
  instr_flag_a: assert property ( // RULE_08
    instrEvt && clkEn |=> !cause_ff[BIT_INSTR] && coreRst_ff)
    else $error("instruction reset flag wrong");
  flat_vec_a: assert property ( // RULE_09
    irqWk && !cause_ff[BIT_PRIO] && clkEn |=> vecAddr_ff == VEC_HIGH)
    else $error("legacy mode used low vector");
  vec_load_a: assert property ( // RULE_10
    irqWk && gieAny && clkEn |=> vecLoad_ff ##1 !vecLoad_ff)
    else $error("wake vector not loaded once");
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
`default_nettype none
module tb
  import reset_cause_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int e; logic slp; logic [7:0] pre; logic [7:0] cause;
    logic [6:0] st; logic rst;} row_s;
  logic clk = 0, srst = 1, clkEn = 1;
  logic [7:0] awaddr = '0, araddr = '0, evt = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic [63:0] flashCfg = 64'h1234_5678_9abc_def0, cfgDisturb = '0;
  logic sleepMode = 0, irqLowLevel = 0, gieHigh = 0, gieLow = 0;
  wire logic awready, wready, bvalid, arready, rvalid, coreRst, wakePulse;
  wire logic vecLoad, priorityEn, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [63:0] activeCfg;
  wire logic [15:0] vecAddr;
  int fail_count = 0, n_compared = 0, cnt;
  logic [31:0] rd;
  logic [1:0] rsp;
  logic [2:0] vt [4] = '{3'b111, 3'b011, 3'b000, 3'b001};
  // events in order: instr, watchdog, clear pin, stack full, stack under,
  // low supply, irq wake, mismatch; watchdog and irq wake sleep rows expect a wake, the clear pin sleep row a reset
  row_s rows [11] = '{
    '{0, 0, 8'h33, 8'h2f, 7'h02, 1}, '{1, 0, 8'h33, 8'h37, 7'h04, 1},
    '{1, 1, 8'h33, 8'h33, 7'h44, 0}, '{2, 1, 8'h33, 8'h3b, 7'h08, 1},
    '{2, 0, 8'h33, 8'h3b, 7'h08, 1}, '{3, 0, 8'h33, 8'h3b, 7'h10, 1},
    '{4, 0, 8'h33, 8'h3b, 7'h10, 1}, '{5, 0, 8'h13, 8'h1e, 7'h20, 1},
    '{6, 1, 8'h33, 8'h3b, 7'h40, 0}, '{7, 0, 8'h33, 8'h1b, 7'h01, 1},
    '{0, 0, 8'h13, 8'h0b, 7'h02, 1}};

  reset_cause_unit u_dut (.clk(clk), .srst(srst), .clkEn(clkEn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .flashCfg(flashCfg), .cfgDisturb(cfgDisturb),
    .activeCfg(activeCfg), .clrPinReq(evt[2]), .rstInstrReq(evt[0]),
    .wdogExpire(evt[1]), .stackFullReq(evt[3]), .stackUnderReq(evt[4]),
    .lowSupplyReq(evt[5]), .sleepMode(sleepMode), .irqWake(evt[6]),
    .irqLowLevel(irqLowLevel), .gieHigh(gieHigh), .gieLow(gieLow),
    .coreRst(coreRst), .wakePulse(wakePulse), .vecLoad(vecLoad),
    .vecAddr(vecAddr), .priorityEn(priorityEn), .irq(irq));

  initial
  begin
    forever #5 clk = ~clk;
  end

  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // master holds each channel until its own handshake edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (n = 0; n < 50 && !(bvalid && bready); n++)
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      rsp = bresp;
    end
    bready <= 0;
    if (n == 50) fail_count++;
  endtask

  task automatic rdr(input logic [7:0] a);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (n = 0; n < 50 && !(rvalid && rready); n++)
    begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 0;
      rd = rdata;
      rsp = rresp;
    end
    rready <= 0;
    if (n == 50) fail_count++;
  endtask

  task automatic fire(input int e);
    @(posedge clk);
    if (e == 7) cfgDisturb <= 64'h1;
    else evt <= 8'(1 << e);
    @(posedge clk);
    evt <= '0;
    cfgDisturb <= '0;
    #1;
    cnt = int'(coreRst === 1'b1);
  endtask

  // adds up hold cycles after fire; also lets a reset run out
  task automatic settle();
    repeat (30)
    begin
      @(posedge clk);
      #1;
      if (coreRst === 1'b1) cnt++;
    end
  endtask

  initial
  begin
    #300us;
    fail_count++;
    end_of_test();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    srst <= 0;
    settle();
    check(cnt, 5);
    check(activeCfg, flashCfg);
    rdr(OFF_CAUSE);
    check(rd, 32'(CAUSE_RST));
    rdr(OFF_EVT);
    check(rd, 0);
    rdr(OFF_MASK);
    check(rd, 0);
    foreach (rows[i])
    begin
      wr(OFF_CAUSE, 32'(rows[i].pre));
      sleepMode <= rows[i].slp;
      fire(rows[i].e);
      check(wakePulse, !rows[i].rst);
      settle();
      sleepMode <= 0;
      check(cnt, rows[i].rst ? 6 : 0);
      check(activeCfg, flashCfg);
      rdr(OFF_CAUSE);
      check(rd, 32'(rows[i].cause));
      rdr(OFF_EVT);
      check(rd & 32'h7f, 32'(rows[i].st));
      wr(OFF_EVT, 32'h7f);
    end
    // wake vectors: low-priority interrupt, split enable and globals varied
    irqLowLevel <= 1;
    for (int k = 0; k < 4; k++)
    begin
      wr(OFF_CAUSE, {24'h0, vt[k][2], 7'h33});
      check(priorityEn, vt[k][2]);
      gieHigh <= vt[k][1];
      gieLow <= vt[k][0];
      sleepMode <= 1;
      fire(6);
      check(vecLoad, vt[k][1] | vt[k][0]);
      if (vt[k][1] | vt[k][0])
        check(vecAddr, vt[k][2] ? VEC_LOW : VEC_HIGH);
      sleepMode <= 0;
      settle();
      check(cnt, 0);
    end
    wr(OFF_EVT, 32'h7f);
    // interrupt raise, mask and clear
    wr(OFF_MASK, 32'h7f);
    check(irq, 0);
    fire(0);
    settle();
    check(irq, 1);
    wr(OFF_MASK, 32'h00);
    check(irq, 0);
    wr(OFF_MASK, 32'h02);
    check(irq, 1);
    rdr(OFF_MASK);
    check(rd, 32'h02);
    wr(OFF_EVT, 32'h02);
    check(irq, 0);
    rdr(OFF_STATE);
    check(rd, 32'h10);
    // clock enable low freezes the sequencer, so the event is not taken
    clkEn <= 0;
    fire(0);
    check(coreRst, 0);
    clkEn <= 1;
    // unmapped offset refused
    wr(8'h10, 32'hff);
    check(rsp, RESP_SLVERR);
    rdr(8'h10);
    check(rsp, RESP_SLVERR);
    check(rd, 0);
    end_of_test();
  end
endmodule
`default_nettype wire
